/* File: logic/adcc_core.sv */
// Purpose: conversion / sleep / data i/o cycle of a delta-sigma converter behind a two-wire slave
// Assumes: modulator supplies its 17-bit code and range flags at conversion end
// Notes: sda is open drain, sda_oe high pulls the line low
`include "adcc_defs.svh"
`default_nettype none
module adcc_core #(
  parameter int unsigned POR_CYCLES = `ADCC_POR_CYCLES,
  parameter int unsigned EXT_CYCLES = `ADCC_EXT_CYCLES,
  parameter int unsigned CONV_TICKS_1X = `ADCC_CONV_TICKS_1X,
  parameter int unsigned CONV_TICKS_2X = `ADCC_CONV_TICKS_2X,
  parameter int unsigned CAL_TICKS = `ADCC_CAL_TICKS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic conversion_clock_select_pin,
  input wire logic address_select_pin_zero,
  input wire logic address_select_pin_zero_float,
  input wire logic address_select_pin_one,
  input wire logic address_select_pin_one_float,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [16:0] mod_value,
  input wire logic mod_over,
  input wire logic mod_under,
  output logic [2:0] mux_pos_sel,
  output logic [2:0] mux_neg_sel,
  output logic [1:0] rejection_mode,
  output logic speed_2x,
  output logic temp_select,
  output logic [2:0] gain_code,
  output logic converting,
  output logic calibrating,
  output logic sleeping,
  output logic ext_clock_active
);
  localparam logic [19:0] POR_INIT = 20'(POR_CYCLES);
  localparam logic [13:0] EXT_INIT = 14'(EXT_CYCLES);
  localparam logic [15:0] LEN_1X = 16'(CONV_TICKS_1X - 1);
  localparam logic [15:0] LEN_2X = 16'(CONV_TICKS_2X - 1);
  localparam logic [15:0] CAL_LEN = 16'(CAL_TICKS);
  localparam logic [27:0] OSC_STEP = 28'(`ADCC_OSC_HZ);
  localparam logic [27:0] CLK_MOD = 28'(`ADCC_CLK_HZ);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] s;
  logic supply_s, fpin_s, scl_s, sda_s;
  adcc_sync #(.W(8), .INIT(8'b0000_0011)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({supply_ok, conversion_clock_select_pin, address_select_pin_zero, address_select_pin_zero_float,
        address_select_pin_one, address_select_pin_one_float, scl, sda_i}),
    .q(s)
  );
  assign supply_s = s[7];
  assign fpin_s = s[6];
  assign scl_s = s[1];
  assign sda_s = s[0];

  logic scl_p_q, sda_p_q, fpin_p_q;
  logic scl_rise, scl_fall, start_det, stop_det, f_rise;
  // ----------------------------------------
  // power-on reset
  // ----------------------------------------
  logic [19:0] por_q;
  logic core_rst;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      por_q <= POR_INIT;
    end else if (!supply_s) begin
      por_q <= POR_INIT;
    end else if (por_q != 20'h0_0000) begin
      por_q <= por_q - 20'h0_0001;
    end
  end
  assign core_rst = !nrst || (por_q != 20'h0_0000);

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      fpin_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      fpin_p_q <= fpin_s;
    end
  end
  // scl only observed, never driven
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && !sda_s && sda_p_q;
  assign stop_det = scl_s && scl_p_q && sda_s && !sda_p_q;
  assign f_rise = fpin_s && !fpin_p_q;

  // ----------------------------------------
  // conversion clock source
  // ----------------------------------------
  logic [13:0] ext_q;
  logic [27:0] acc_q;
  logic [27:0] acc_sum;
  logic osc_tick, conv_tick;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      ext_q <= 14'h0000;
    end else if (f_rise) begin
      ext_q <= EXT_INIT;
    end else if (ext_q != 14'h0000) begin
      ext_q <= ext_q - 14'h0001;
    end
  end
  // fractional accumulator: average rate exact, jitter of one system clock
  assign acc_sum = acc_q + OSC_STEP;
  assign osc_tick = acc_sum >= CLK_MOD;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      acc_q <= 28'h000_0000;
    end else begin
      acc_q <= osc_tick ? acc_sum - CLK_MOD : acc_sum;
    end
  end
  assign ext_clock_active = ext_q != 14'h0000;
  assign conv_tick = ext_clock_active ? f_rise : osc_tick;

  // ----------------------------------------
  // operating cycle
  // ----------------------------------------
  adcc_pkg::adcc_cyc_type cst_q;
  adcc_pkg::adcc_bus_type bus_q;
  logic [15:0] tick_q;
  logic [3:0] bitcnt_q;
  logic [7:0] sh_q;
  logic rw_q;
  logic [23:0] result_q, rd_sh_q;
  logic [4:0] rd_bits_q;
  logic rd_done_q;
  logic conv_done, start_conv, rd_full, addr_ack, addr_ok, wr_byte;
  logic [3:0] acode;
  logic [6:0] my_addr;

  assign conv_done = (cst_q == adcc_pkg::C_CONV) && conv_tick && (tick_q == (speed_2x ? LEN_2X : LEN_1X));
  assign rd_full = (bus_q == adcc_pkg::B_RD) && scl_rise && (rd_bits_q == 5'd23);
  assign start_conv = (stop_det && (cst_q == adcc_pkg::C_IO)) || rd_full;

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      cst_q <= adcc_pkg::C_CONV;
    end else begin
      case (cst_q)
        adcc_pkg::C_CONV: if (conv_done) cst_q <= adcc_pkg::C_SLEEP;
        adcc_pkg::C_SLEEP: if (addr_ack) cst_q <= adcc_pkg::C_IO;
        adcc_pkg::C_IO: if (start_conv) cst_q <= adcc_pkg::C_CONV;
        default: cst_q <= adcc_pkg::C_CONV;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst || cst_q != adcc_pkg::C_CONV) begin
      tick_q <= 16'h0000;
    end else if (conv_tick) begin
      tick_q <= tick_q + 16'h0001;
    end
  end
  assign converting = cst_q == adcc_pkg::C_CONV;
  assign sleeping = cst_q == adcc_pkg::C_SLEEP;
  // calibration slice at the head of each conversion, length unchanged
  assign calibrating = converting && (tick_q < CAL_LEN);

  // result latched once per conversion end, then frozen
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      result_q <= 24'h00_0000;
    end else if (conv_done) begin
      if (mod_over) begin
        result_q <= `ADCC_RES_OVER;
      end else if (mod_under) begin
        result_q <= `ADCC_RES_UNDER;
      end else begin
        result_q <= {~mod_value[16], mod_value, 6'h00};
      end
    end
  end

  // ----------------------------------------
  // slave address
  // ----------------------------------------
  always_comb begin
    acode = 4'h0;
    acode = acode + (s[4] ? 4'h2 : {3'h0, s[5]});
    acode = acode + 4'h3 * (s[2] ? 4'h2 : {3'h0, s[3]});
  end
  assign my_addr = `ADCC_ADDR_BASE + {3'h0, acode};
  assign addr_ok = (sh_q[7:1] == my_addr) && (cst_q != adcc_pkg::C_CONV);
  assign addr_ack = (bus_q == adcc_pkg::B_ADDR) && scl_fall && (bitcnt_q == 4'h8) && addr_ok;
  assign wr_byte = (bus_q == adcc_pkg::B_WR) && scl_fall && (bitcnt_q == 4'h8);

  // ----------------------------------------
  // two-wire slave engine
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      sh_q <= 8'h00;
    end else if (scl_rise && (bus_q == adcc_pkg::B_ADDR || bus_q == adcc_pkg::B_WR)) begin
      sh_q <= {sh_q[6:0], sda_s};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      bus_q <= adcc_pkg::B_IDLE;
      bitcnt_q <= 4'h0;
      rw_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      bus_q <= adcc_pkg::B_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      bus_q <= adcc_pkg::B_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (bus_q)
        adcc_pkg::B_ADDR: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            if (addr_ok) begin
              bus_q <= adcc_pkg::B_AACK;
              sda_oe <= 1'b1;
              rw_q <= sh_q[0];
            end else begin
              bus_q <= adcc_pkg::B_IDLE;
            end
          end
        end
        adcc_pkg::B_AACK: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              bus_q <= adcc_pkg::B_RD;
              sda_oe <= ~rd_sh_q[23];
            end else begin
              bus_q <= adcc_pkg::B_WR;
              sda_oe <= 1'b0;
            end
          end
        end
        adcc_pkg::B_RD: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              bus_q <= adcc_pkg::B_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~rd_sh_q[23];
            end
          end
        end
        adcc_pkg::B_RACK: begin
          if (scl_rise && sda_s) begin
            bus_q <= adcc_pkg::B_IDLE;
          end else if (scl_fall) begin
            if (rd_done_q) begin
              bus_q <= adcc_pkg::B_IDLE;
            end else begin
              bus_q <= adcc_pkg::B_RD;
              bitcnt_q <= 4'h0;
              sda_oe <= ~rd_sh_q[23];
            end
          end
        end
        adcc_pkg::B_WR: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (wr_byte) begin
            bus_q <= adcc_pkg::B_WACK;
            sda_oe <= 1'b1;
          end
        end
        adcc_pkg::B_WACK: begin
          if (scl_fall) begin
            bus_q <= adcc_pkg::B_WR;
            bitcnt_q <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        default: bus_q <= adcc_pkg::B_IDLE;
      endcase
    end
  end
  assign sda_o = 1'b0;

  // read shifter loads the held result straight away: no pipeline stage
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      rd_sh_q <= 24'h00_0000;
      rd_bits_q <= 5'd0;
      rd_done_q <= 1'b0;
    end else if (addr_ack) begin
      rd_sh_q <= result_q;
      rd_bits_q <= 5'd0;
      rd_done_q <= 1'b0;
    end else if (bus_q == adcc_pkg::B_RD && scl_rise) begin
      rd_sh_q <= {rd_sh_q[22:0], 1'b0};
      rd_bits_q <= rd_bits_q + 5'd1;
      if (rd_bits_q == 5'd23) begin
        rd_done_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // configuration word
  // ----------------------------------------
  logic [1:0] byte_idx_q;
  logic [7:0] wr_hi_q;
  logic [15:0] cfg_q;
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      byte_idx_q <= 2'd0;
      wr_hi_q <= 8'h00;
      cfg_q <= `ADCC_CFG_RESET;
    end else if (addr_ack) begin
      byte_idx_q <= 2'd0;
    end else if (wr_byte) begin
      if (byte_idx_q != 2'd2) begin
        byte_idx_q <= byte_idx_q + 2'd1;
      end
      if (byte_idx_q == 2'd0) begin
        wr_hi_q <= sh_q;
      end else if (byte_idx_q == 2'd1) begin
        cfg_q[15:8] <= wr_hi_q;
        if (sh_q[`ADCC_CFG_EN2]) begin
          cfg_q[7:0] <= sh_q;
        end
      end
    end
  end

  // settings move to the converter only when a conversion starts
  always_ff @(posedge clk_sys) begin
    if (core_rst) begin
      mux_pos_sel <= 3'h0;
      mux_neg_sel <= 3'h1;
      rejection_mode <= 2'h0;
      speed_2x <= 1'b0;
      temp_select <= 1'b0;
      gain_code <= 3'h0;
    end else if (start_conv) begin
      mux_pos_sel <= {1'b0, cfg_q[`ADCC_CFG_CHAN], cfg_q[`ADCC_CFG_ODD]};
      if (cfg_q[`ADCC_CFG_SGL]) begin
        mux_neg_sel <= `ADCC_MUX_COMMON;
      end else begin
        mux_neg_sel <= {1'b0, cfg_q[`ADCC_CFG_CHAN], ~cfg_q[`ADCC_CFG_ODD]};
      end
      rejection_mode <= cfg_q[`ADCC_CFG_REJ +: 2];
      speed_2x <= cfg_q[`ADCC_CFG_SPD];
      temp_select <= cfg_q[`ADCC_CFG_TEMP];
      gain_code <= cfg_q[`ADCC_CFG_GAIN +: 3];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (core_rst);

  sequence seq_conv_end;
    (cst_q == adcc_pkg::C_CONV) ##0 conv_done;
  endsequence
  sequence seq_last_bit;
    (bus_q == adcc_pkg::B_RD) ##0 scl_rise ##0 (rd_bits_q == 5'd23);
  endsequence

  chk_sleep_entry: assert property (seq_conv_end |=> sleeping ##1 !converting)
    else $error("no sleep after conversion");
  chk_result_hold: assert property ((sleeping && $past(sleeping)) |-> $stable(result_q))
    else $error("result moved in sleep");
  chk_nak_busy: assert property ((bus_q == adcc_pkg::B_ADDR && scl_fall && bitcnt_q == 4'h8 && converting)
    |=> !sda_oe && bus_q == adcc_pkg::B_IDLE)
    else $error("acknowledged while converting");
  chk_auto_restart: assert property (seq_last_bit |=> converting && rd_done_q)
    else $error("no restart after full read");
  chk_stop_restart: assert property ((stop_det && cst_q == adcc_pkg::C_IO) |=> converting ##1 converting)
    else $error("stop did not start conversion");
  chk_oe_on_fall: assert property ($rose(sda_oe) |-> $past(scl_fall))
    else $error("sda pulled low off a falling edge");
  chk_oe_phase: assert property (sda_oe |-> (bus_q inside {adcc_pkg::B_AACK, adcc_pkg::B_RD, adcc_pkg::B_WACK}))
    else $error("sda driven outside ack or read");
  chk_cfg_apply: assert property (start_conv |=> speed_2x == $past(cfg_q[`ADCC_CFG_SPD])
    && gain_code == $past(cfg_q[2:0]))
    else $error("settings not applied at start");
  chk_single_com: assert property ((start_conv && cfg_q[`ADCC_CFG_SGL]) |=> mux_neg_sel == `ADCC_MUX_COMMON)
    else $error("single-ended negative not common");
  chk_over_code: assert property ((conv_done && mod_over) |=> result_q[23:22] == 2'b11)
    else $error("over-range code wrong");
  chk_por_hold: assert property (@(posedge clk_sys) disable iff (!nrst) !supply_s |=> core_rst ##1 core_rst)
    else $error("reset released with low supply");
endmodule
`default_nettype wire

/* File: logic/adcc_defs.svh */
// Purpose: constants of the conversion-cycle controller
// Assumes: 200 MHz system clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ----------------------------------------
// clocking
// ----------------------------------------
`define ADCC_CLK_HZ 200000000
`define ADCC_CLK_MHZ 200
`define ADCC_OSC_HZ 307200
`define ADCC_POR_MS 4
`define ADCC_POR_CYCLES (`ADCC_POR_MS * `ADCC_CLK_MHZ * 1000)
`define ADCC_EXT_HALF_US 50
`define ADCC_EXT_CYCLES (`ADCC_EXT_HALF_US * `ADCC_CLK_MHZ)

// ----------------------------------------
// conversion lengths in conversion clock ticks
// ----------------------------------------
`define ADCC_CONV_TICKS_1X 41036
`define ADCC_CONV_TICKS_2X 20556
`define ADCC_CAL_TICKS 1024

// ----------------------------------------
// slave address and configuration layout
// ----------------------------------------
`define ADCC_ADDR_BASE 7'h14
`define ADCC_CFG_RESET 16'h0000
`define ADCC_CFG_SGL 12
`define ADCC_CFG_ODD 11
`define ADCC_CFG_CHAN 8
`define ADCC_CFG_EN2 7
`define ADCC_CFG_TEMP 6
`define ADCC_CFG_REJ 4
`define ADCC_CFG_SPD 3
`define ADCC_CFG_GAIN 0
`define ADCC_MUX_COMMON 3'h4

// ----------------------------------------
// result codes
// ----------------------------------------
`define ADCC_RES_OVER 24'hc0_0000
`define ADCC_RES_UNDER 24'h3f_ffc0

`endif

/* File: logic/adcc_pkg.sv */
// Purpose: types of the conversion-cycle controller
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package adcc_pkg;
  typedef enum logic [2:0] {
    C_CONV = 3'b001,
    C_SLEEP = 3'b010,
    C_IO = 3'b100
  } adcc_cyc_type;

  typedef enum logic [6:0] {
    B_IDLE = 7'b000_0001,
    B_ADDR = 7'b000_0010,
    B_AACK = 7'b000_0100,
    B_RD = 7'b000_1000,
    B_RACK = 7'b001_0000,
    B_WR = 7'b010_0000,
    B_WACK = 7'b100_0000
  } adcc_bus_type;
endpackage
`default_nettype wire

/* File: logic/adcc_sync.sv */
// Purpose: three-flop input synchroniser, one chain per bit
// Assumes: inputs asynchronous to clk_sys
// Notes: output moves only when flops two and three agree
`default_nettype none
module adcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic [2:0] f_q;
      logic q_q;
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          f_q <= {3{INIT[i]}};
          q_q <= INIT[i];
        end else begin
          f_q <= {f_q[1:0], d[i]};
          // glitch filter: only an agreed level passes
          if (f_q[1] == f_q[2]) begin
            q_q <= f_q[2];
          end
        end
      end
      assign q[i] = q_q;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: sim/adcc_master.sv */
// Purpose: two-wire bus master model facing the slave port
// Assumes: sda is the wired-and level built in the bench
// Notes: half bit is H clk_sys cycles; data moves two cycles after scl falls
`default_nettype none
module adcc_master #(
  parameter int H = 10
) (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic pull,
  output logic ack_v,
  output logic ack_bit,
  output logic rx_v,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    ack_v = 1'b0;
    ack_bit = 1'b0;
    rx_v = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // delay after scl fall: slave sync sees scl and sda with equal lag
  task automatic bitx(input logic b, output logic s);
    tick(2);
    pull = ~b;
    tick(H);
    scl = 1'b1;
    tick(H);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    tick(2);
    pull = 1'b0;
    tick(H);
    scl = 1'b1;
    tick(H);
    pull = 1'b1;
    tick(H);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    pull = 1'b1;
    tick(H);
    scl = 1'b1;
    tick(H);
    pull = 1'b0;
    tick(H);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack_bit = s;
    ack_v = 1'b1;
    tick(1);
    ack_v = 1'b0;
  endtask
  // last byte is refused by the master, which ends the read
  task automatic rbyte(input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      rx_byte[i] = s;
    end
    bitx(last, s);
    rx_v = 1'b1;
    tick(1);
    rx_v = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/adcc_core_tb.sv */
// Purpose: self-checking bench of the conversion-cycle controller
// Assumes: shortened counts, external conversion clock of 80 ns
// Notes: driver queues expected bytes and acks, monitor pops and compares
`default_nettype none
module adcc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] addr;
  logic pin0, pin0_float, pin1, pin1_float;
  int t0, t1;
  logic clk_sys, nrst, supply_ok, fpin, ext_on, scl, sda, pull, sda_o, sda_oe, ext_act;
  logic mod_over, mod_under, converting, calibrating, sleeping, ack_v, ack_bit, rx_v, speed_2x, temp_select;
  logic [16:0] mod_value;
  logic [2:0] mux_pos_sel, mux_neg_sel, gain_code;
  logic [1:0] rejection_mode;
  logic [7:0] rx_byte;
  logic [23:0] word;
  logic [15:0] cfgs [4] = '{16'h19ed, 16'h0180, 16'h1090, 16'h08b7};
  logic [7:0] q_byte[$];
  logic q_ack[$];
  int fails, samples_checked, n;
  // ----
  // wiring: pull-up on the open-drain data line
  // ----
  assign sda = ~((sda_oe & ~sda_o) | pull);
  adcc_core #(.POR_CYCLES(20), .EXT_CYCLES(200), .CONV_TICKS_1X(40), .CONV_TICKS_2X(32), .CAL_TICKS(4)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .supply_ok(supply_ok), .conversion_clock_select_pin(fpin),
    .address_select_pin_zero(pin0), .address_select_pin_zero_float(pin0_float),
    .address_select_pin_one(pin1), .address_select_pin_one_float(pin1_float),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .mod_value(mod_value), .mod_over(mod_over), .mod_under(mod_under),
    .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel), .rejection_mode(rejection_mode),
    .speed_2x(speed_2x), .temp_select(temp_select), .gain_code(gain_code), .converting(converting),
    .calibrating(calibrating), .sleeping(sleeping), .ext_clock_active(ext_act));
  adcc_master #(.H(10)) m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .pull(pull), .ack_v(ack_v),
    .ack_bit(ack_bit), .rx_v(rx_v), .rx_byte(rx_byte));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    fpin = 1'b0;
    #17;
    forever #40 if (ext_on) fpin = ~fpin;
  end
  // ----
  // checking
  // ----
  task automatic cmp_ack(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t ack exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t byte exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_port(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t port exp %h got %h", $time, e, g);
    end
  endtask
  always @(posedge clk_sys) begin
    if (ack_v) cmp_ack(q_ack.pop_front(), ack_bit);
    if (rx_v) cmp_byte(q_byte.pop_front(), rx_byte);
  end
  task automatic results();
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----
  // stimulus
  // ----
  task automatic arm(input logic o, input logic u);
    mod_value = 17'($urandom);
    mod_over = o;
    mod_under = u;
    word = o ? 24'hc0_0000 : u ? 24'h3f_ffc0 : {~mod_value[16], mod_value, 6'h00};
  endtask
  task automatic chk_cfg(input logic [15:0] w);
    cmp_port({5'h00, mux_pos_sel}, {6'h00, w[8], w[11]});
    cmp_port({5'h00, mux_neg_sel}, w[12] ? 8'h04 : {6'h00, w[8], ~w[11]});
    cmp_port({1'b0, rejection_mode, speed_2x, temp_select, gain_code}, {1'b0, w[5:4], w[3], w[6], w[2:0]});
  endtask
  task automatic wait_sleep(input int lim);
    n = 0;
    while (sleeping !== 1'b1) begin
      m.tick(1);
      n++;
      if (n > lim) begin
        fails++;
        results();
      end
    end
    cmp_port({6'h00, converting, calibrating}, 8'h00);
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    m.start();
    q_ack.push_back(e);
    m.wbyte({a, 1'b1});
    m.stop();
  endtask
  // one i/o cycle: optional config write, then a read of nb bytes
  task automatic io(input logic wr, input logic [15:0] cfg, input int nb);
    if (wr) begin
      m.start();
      q_ack.push_back(1'b0);
      m.wbyte({addr, 1'b0});
      q_ack.push_back(1'b0);
      m.wbyte(cfg[15:8]);
      q_ack.push_back(1'b0);
      m.wbyte(cfg[7:0]);
    end
    if (nb > 0) begin
      m.start();
      q_ack.push_back(1'b0);
      m.wbyte({addr, 1'b1});
      for (int i = 0; i < nb; i++) begin
        q_byte.push_back(word[23 - 8 * i -: 8]);
        m.rbyte(i == nb - 1);
      end
      cmp_port({7'h00, converting}, {7'h00, nb == 3});
    end
    m.stop();
    m.tick(20);
    // a conversion begun at the stop is still in its calibration slice here
    cmp_port({6'h00, converting, calibrating}, {6'h00, 1'b1, nb < 3});
  endtask
  initial begin
    nrst = 1'b0;
    supply_ok = 1'b1;
    ext_on = 1'b0;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'h566b_4b45));
    // random three-state levels on both address pins: 0 low, 1 high, 2 floating
    t0 = $urandom % 3;
    t1 = $urandom % 3;
    pin0 = t0 == 1;
    pin0_float = t0 == 2;
    pin1 = t1 == 1;
    pin1_float = t1 == 2;
    addr = 7'h14 + 7'(t0 + 3 * t1);
    arm(1'b0, 1'b0);
    repeat (20) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    // let the power-on reset run out, else the start goes unseen
    m.tick(60);
    probe(addr, 1'b1);
    chk_cfg(16'h0000);
    wait_sleep(40000);
    cmp_port({7'h00, n inside {[24000:30000]}}, 8'h01);
    mod_value = ~mod_value;
    probe(addr ^ 7'h40, 1'b1);
    ext_on = 1'b1;
    m.tick(100);
    cmp_port({6'h00, sleeping, ext_act}, 8'h03);
    // first pass is the first i/o cycle after reset; the four passes together walk all rejection codes
    for (int k = 0; k < 4; k++) begin
      io(1'b1, cfgs[k], 3);
      arm(k == 1, k == 2);
      probe(addr, 1'b1);
      chk_cfg(cfgs[k]);
      wait_sleep(3000);
      mod_value = ~mod_value;
    end
    io(1'b0, 16'h0000, 1);
    arm(1'b0, 1'b0);
    wait_sleep(3000);
    io(1'b1, 16'h1000, 0);
    chk_cfg(16'h10b7);
    supply_ok = 1'b0;
    m.tick(10);
    cmp_port({7'h00, converting}, 8'h01);
    supply_ok = 1'b1;
    m.tick(30);
    chk_cfg(16'h0000);
    results();
  end
endmodule
`default_nettype wire
